// >>> verilog/variable_bank_pkg.sv
// Constants, identifiers and carrier types of the controller variable bank
package variable_bank_pkg;

  // ------------------------------------------------------------------
  // Variable identifiers
  // ------------------------------------------------------------------
  localparam logic [7:0] ID_PULSE1_UNLIM = 8'h04;
  localparam logic [7:0] ID_PULSE1_LIM = 8'h05;
  localparam logic [7:0] ID_PULSE1_SCALED = 8'h06;
  localparam logic [7:0] ID_PULSE2_UNLIM = 8'h08;
  localparam logic [7:0] ID_PULSE2_LIM = 8'h09;
  localparam logic [7:0] ID_PULSE2_SCALED = 8'h0a;
  localparam logic [7:0] ID_ANALOG1_UNLIM = 8'h0c;
  localparam logic [7:0] ID_ANALOG1_LIM = 8'h0d;
  localparam logic [7:0] ID_ANALOG1_SCALED = 8'h0e;
  localparam logic [7:0] ID_ANALOG2_UNLIM = 8'h10;
  localparam logic [7:0] ID_ANALOG2_LIM = 8'h11;
  localparam logic [7:0] ID_ANALOG2_SCALED = 8'h12;
  localparam logic [7:0] ID_REQUESTED_SPEED = 8'h14;
  localparam logic [7:0] ID_APPLIED_SPEED = 8'h15;
  localparam logic [7:0] ID_BRAKING = 8'h16;
  localparam logic [7:0] ID_SUPPLY_MV = 8'h17;
  localparam logic [7:0] ID_TEMPERATURE = 8'h18;
  localparam logic [7:0] ID_PULSE_PERIOD = 8'h1a;
  localparam logic [7:0] ID_RATE_DIVISOR = 8'h1b;
  localparam logic [7:0] ID_UPTIME_LOW = 8'h1c;
  localparam logic [7:0] ID_UPTIME_HIGH = 8'h1d;

  // ------------------------------------------------------------------
  // Values and limits
  // ------------------------------------------------------------------
  localparam logic [15:0] RAW_NONE = 16'hffff;
  localparam logic [15:0] BRAKE_MOVING = 16'h00ff;
  localparam logic signed [15:0] SCALED_MAX = 16'sh0c80;
  localparam logic signed [15:0] SCALED_MIN = -16'sh0c80;
  localparam int SCALE_SHIFT = 8;
  localparam logic [15:0] PULSE_MIN_Q = 16'h0190;
  localparam logic [15:0] PULSE_MAX_Q = 16'h2ee0;
  localparam logic [15:0] PULSE_TIMEOUT_T = 16'h01f4;
  localparam logic [15:0] COUNT_SAT = 16'hfffe;

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int QUARTER_US_NS = 250;
  localparam int TENTH_MS_NS = 100000;
  localparam int MS_NS = 1000000;
  localparam int TENTH_MS_CYCLES = TENTH_MS_NS / CLK_PERIOD_NS;
  localparam int MS_CYCLES_DEFAULT = MS_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Carrier types
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] err_min;
    logic [15:0] err_max;
    logic [15:0] neutral;
    logic [15:0] gain;
  } cal_t;

  typedef struct packed {
    logic signed [15:0] target;
    logic signed [15:0] speed;
    logic [5:0] brake;
    logic [15:0] supply_mv;
    logic signed [15:0] temp_tenths;
    logic [15:0] divisor;
    logic auto_rate;
    logic rate_found;
  } diag_t;

  typedef enum logic [1:0] {
    PH_WAIT = 2'b00,
    PH_HIGH = 2'b01,
    PH_LOW = 2'b11
  } pulse_phase_t;

  typedef struct packed {
    pulse_phase_t phase;
    logic pin_prev;
    logic [15:0] width_cnt;
    logic [15:0] width;
    logic valid;
    logic [15:0] age;
    logic [15:0] period_cnt;
    logic [15:0] period;
  } pulse_ch_t;

  typedef struct packed {
    logic [11:0] code;
    logic open;
  } adc_ch_t;

endpackage

// >>> verilog/variable_bank.sv
// Read-only controller variable bank: pulse and analog inputs, diagnostics
`timescale 1ns/1ps

module variable_bank
  import variable_bank_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DEFAULT  // Clock cycles per millisecond
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic pulse_input_one_i,
  input wire logic pulse_input_two_i,
  input wire logic adc_strobe_i,
  input wire logic adc_channel_i,
  input wire logic [11:0] adc_code_i,
  input wire logic [1:0] pot_open_i,
  input wire logic open_detect_en_i,
  input wire cal_t [3:0] channel_cal_i,
  input wire diag_t diag_i,
  input wire logic var_req_i,
  input wire logic [7:0] var_id_i,
  output logic var_ack_o,
  output logic [15:0] var_data_o,
  output logic var_unknown_o
);

  // ------------------------------------------------------------------
  // State and helpers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [8:0] qacc;          // Quarter-microsecond phase accumulator
    logic [11:0] tenth_cnt;    // Tenth-millisecond prescaler
    logic [15:0] ms_cnt;       // Millisecond prescaler
    logic [31:0] uptime;       // Milliseconds since reset
    pulse_ch_t [1:0] pulse;    // Pulse channel measurement
    adc_ch_t [1:0] adc;        // Latest converter results
    diag_t diag;               // Registered diagnostics
    logic ack;                 // Answer strobe
    logic unknown;             // Unmapped identifier flag
    logic [15:0] data;         // Answer word
  } bank_state_t;

  bank_state_t st_q;  // Registered state
  bank_state_t st_d;  // Next state

  // Limit a raw reading against the fault bounds
  function automatic logic [15:0] limit_raw(input logic [15:0] raw, input cal_t cal);
    if (raw == RAW_NONE || raw < cal.err_min || raw > cal.err_max)
      return RAW_NONE;
    return raw;
  endfunction

  // Scale a limited reading into speed units with clamping
  function automatic logic [15:0] scale_raw(input logic [15:0] lim, input cal_t cal);
    logic signed [16:0] diff;
    logic signed [33:0] prod;
    logic signed [33:0] shifted;
    diff = $signed({1'b0, lim}) - $signed({1'b0, cal.neutral});
    prod = diff * $signed({1'b0, cal.gain});
    shifted = prod >>> SCALE_SHIFT;
    if (lim == RAW_NONE)
      return 16'h0000;
    if (shifted > 34'(SCALED_MAX))
      return SCALED_MAX;
    if (shifted < 34'(SCALED_MIN))
      return SCALED_MIN;
    return shifted[15:0];
  endfunction

  // Unlimited pulse value: width while valid, else all ones
  function automatic logic [15:0] pulse_unlim(input pulse_ch_t ch);
    return ch.valid ? ch.width : RAW_NONE;
  endfunction

  // Unlimited analog value: code, or all ones when open
  function automatic logic [15:0] analog_unlim(input adc_ch_t ch);
    return ch.open ? RAW_NONE : {4'h0, ch.code};
  endfunction

  // Saturating increment used by all pulse counters
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v >= COUNT_SAT) ? COUNT_SAT : v + 16'h0001;
  endfunction

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  logic qtick;        // Quarter-microsecond tick
  logic ttick;        // Tenth-millisecond tick
  logic [1:0] pins;   // Pulse pins by channel
  logic [15:0] lim_v; // Scratch limited value
  logic [15:0] rd;    // Read mux result
  logic unk;          // Read of an unmapped identifier

  always_comb
  begin
    st_d = st_q;
    pins = {pulse_input_two_i, pulse_input_one_i};
    lim_v = 16'h0000;
    rd = 16'h0000;
    unk = 1'b0;

    // Quarter-microsecond tick from a fractional accumulator
    qtick = (st_q.qacc + 9'(CLK_PERIOD_NS)) >= 9'(QUARTER_US_NS);
    if (qtick)
      st_d.qacc = st_q.qacc + 9'(CLK_PERIOD_NS) - 9'(QUARTER_US_NS);
    else
      st_d.qacc = st_q.qacc + 9'(CLK_PERIOD_NS);

    // Tenth-millisecond tick for period and timeout
    ttick = st_q.tenth_cnt == 12'(TENTH_MS_CYCLES - 1);
    st_d.tenth_cnt = ttick ? 12'h000 : st_q.tenth_cnt + 12'h001;

    // Millisecond uptime counter
    if (st_q.ms_cnt == 16'(MS_CYCLES - 1))
    begin
      st_d.ms_cnt = 16'h0000;
      st_d.uptime = st_q.uptime + 32'h0000_0001;
    end
    else
    begin
      st_d.ms_cnt = st_q.ms_cnt + 16'h0001;
    end

    // Pulse channels run in every input mode
    for (int i = 0; i < 2; i++)
    begin
      st_d.pulse[i].pin_prev = pins[i];
      if (ttick)
      begin
        st_d.pulse[i].age = sat_inc(st_q.pulse[i].age);
        st_d.pulse[i].period_cnt = sat_inc(st_q.pulse[i].period_cnt);
      end
      // Signal lost after the timeout; a good pulse in the same cycle still wins
      if (st_q.pulse[i].age >= PULSE_TIMEOUT_T)
        st_d.pulse[i].valid = 1'b0;
      if (qtick && st_q.pulse[i].phase == PH_HIGH)
        st_d.pulse[i].width_cnt = sat_inc(st_q.pulse[i].width_cnt);
      case (st_q.pulse[i].phase)
        PH_WAIT:
        begin
          // First rising edge starts a measurement
          if (pins[i] && !st_q.pulse[i].pin_prev)
          begin
            st_d.pulse[i].phase = PH_HIGH;
            st_d.pulse[i].width_cnt = 16'h0000;
            st_d.pulse[i].period_cnt = 16'h0000;
          end
        end
        PH_HIGH:
        begin
          // Falling edge: accept width only inside the pulse window
          if (!pins[i])
          begin
            st_d.pulse[i].phase = PH_LOW;
            if (st_q.pulse[i].width_cnt >= PULSE_MIN_Q && st_q.pulse[i].width_cnt <= PULSE_MAX_Q)
            begin
              st_d.pulse[i].width = st_q.pulse[i].width_cnt;
              st_d.pulse[i].valid = 1'b1;
              st_d.pulse[i].age = 16'h0000;
            end
            else
            begin
              st_d.pulse[i].valid = 1'b0;
            end
          end
        end
        PH_LOW:
        begin
          // Rising edge: close the period and restart the width count
          if (pins[i])
          begin
            st_d.pulse[i].phase = PH_HIGH;
            st_d.pulse[i].width_cnt = 16'h0000;
            st_d.pulse[i].period = st_q.pulse[i].period_cnt;
            st_d.pulse[i].period_cnt = 16'h0000;
          end
        end
        default:
        begin
          st_d.pulse[i].phase = PH_WAIT;
        end
      endcase
    end

    // Analog channels sampled in every input mode
    if (adc_strobe_i)
      st_d.adc[adc_channel_i].code = adc_code_i;
    st_d.adc[0].open = pot_open_i[0] && open_detect_en_i;
    st_d.adc[1].open = pot_open_i[1] && open_detect_en_i;

    // Diagnostics captured every cycle
    st_d.diag = diag_i;

    // Read mux: function of the state, the identifier and the unregistered calibration inputs
    case (var_id_i)
      ID_PULSE1_UNLIM: rd = pulse_unlim(st_q.pulse[0]);
      ID_PULSE1_LIM: rd = limit_raw(pulse_unlim(st_q.pulse[0]), channel_cal_i[0]);
      ID_PULSE1_SCALED:
      begin
        lim_v = limit_raw(pulse_unlim(st_q.pulse[0]), channel_cal_i[0]);
        rd = scale_raw(lim_v, channel_cal_i[0]);
      end
      ID_PULSE2_UNLIM: rd = pulse_unlim(st_q.pulse[1]);
      ID_PULSE2_LIM: rd = limit_raw(pulse_unlim(st_q.pulse[1]), channel_cal_i[1]);
      ID_PULSE2_SCALED:
      begin
        lim_v = limit_raw(pulse_unlim(st_q.pulse[1]), channel_cal_i[1]);
        rd = scale_raw(lim_v, channel_cal_i[1]);
      end
      ID_ANALOG1_UNLIM: rd = analog_unlim(st_q.adc[0]);
      ID_ANALOG1_LIM: rd = limit_raw(analog_unlim(st_q.adc[0]), channel_cal_i[2]);
      ID_ANALOG1_SCALED:
      begin
        lim_v = limit_raw(analog_unlim(st_q.adc[0]), channel_cal_i[2]);
        rd = scale_raw(lim_v, channel_cal_i[2]);
      end
      ID_ANALOG2_UNLIM: rd = analog_unlim(st_q.adc[1]);
      ID_ANALOG2_LIM: rd = limit_raw(analog_unlim(st_q.adc[1]), channel_cal_i[3]);
      ID_ANALOG2_SCALED:
      begin
        lim_v = limit_raw(analog_unlim(st_q.adc[1]), channel_cal_i[3]);
        rd = scale_raw(lim_v, channel_cal_i[3]);
      end
      ID_REQUESTED_SPEED: rd = st_q.diag.target;
      ID_APPLIED_SPEED: rd = st_q.diag.speed;
      ID_BRAKING: rd = (st_q.diag.speed == 16'sh0000) ? {10'h000, st_q.diag.brake} : BRAKE_MOVING;
      ID_SUPPLY_MV: rd = st_q.diag.supply_mv;
      ID_TEMPERATURE: rd = st_q.diag.temp_tenths[15] ? 16'h0000 : st_q.diag.temp_tenths;
      ID_PULSE_PERIOD: rd = st_q.pulse[0].valid ? st_q.pulse[0].period : 16'h0000;
      ID_RATE_DIVISOR: rd = (st_q.diag.auto_rate && !st_q.diag.rate_found) ? 16'h0000 : st_q.diag.divisor;
      ID_UPTIME_LOW: rd = st_q.uptime[15:0];
      ID_UPTIME_HIGH: rd = st_q.uptime[31:16];
      default: unk = 1'b1;
    endcase

    // Answer one cycle after the request; nothing else changes
    st_d.ack = var_req_i;
    st_d.data = var_req_i ? rd : st_q.data;
    st_d.unknown = var_req_i ? unk : st_q.unknown;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign var_ack_o = st_q.ack;
  assign var_data_o = st_q.data;
  assign var_unknown_o = st_q.unknown;

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  a_raw_none_invalid: assert property (
    var_req_i && var_id_i == ID_PULSE1_UNLIM && !st_q.pulse[0].valid |=> var_data_o == RAW_NONE)
    else $error("Unlimited pulse raw not all ones without signal");
  a_limited_bounds: assert property (
    var_req_i && var_id_i == ID_PULSE2_LIM && st_q.pulse[1].valid
    && st_q.pulse[1].width > channel_cal_i[1].err_max |=> var_data_o == RAW_NONE)
    else $error("Limited pulse raw not all ones above bound");
  a_scaled_range: assert property (
    var_req_i && var_id_i == ID_ANALOG1_SCALED
    |=> $signed(var_data_o) <= SCALED_MAX && $signed(var_data_o) >= SCALED_MIN)
    else $error("Scaled value outside speed range");
  a_scaled_none: assert property (
    var_req_i && var_id_i == ID_PULSE1_SCALED && !st_q.pulse[0].valid |=> var_data_o == 16'h0000)
    else $error("Scaled pulse value nonzero without signal");
  a_analog_open: assert property (
    (pot_open_i[0] && open_detect_en_i) ##1 (var_req_i && var_id_i == ID_ANALOG1_UNLIM)
    |=> var_data_o == RAW_NONE)
    else $error("Open pot not reported as all ones");
  a_open_scaled: assert property (
    (pot_open_i[1] && open_detect_en_i) ##1 (var_req_i && var_id_i == ID_ANALOG2_SCALED)
    |=> var_data_o == 16'h0000)
    else $error("Open pot scaled value not zero");
  a_brake_moving: assert property (
    var_req_i && var_id_i == ID_BRAKING && st_q.diag.speed != 16'sh0000 |=> var_data_o == BRAKE_MOVING)
    else $error("Brake value wrong while moving");
  a_brake_upper: assert property (
    var_req_i && var_id_i == ID_BRAKING |=> var_data_o[15:8] == 8'h00)
    else $error("Brake value upper byte not zero");
  a_temp_clamp: assert property (
    var_req_i && var_id_i == ID_TEMPERATURE |=> !var_data_o[15])
    else $error("Negative temperature reported");
  a_period_invalid: assert property (
    var_req_i && var_id_i == ID_PULSE_PERIOD && !st_q.pulse[0].valid |=> var_data_o == 16'h0000)
    else $error("Period nonzero without signal");
  a_divisor_auto: assert property (
    var_req_i && var_id_i == ID_RATE_DIVISOR && st_q.diag.auto_rate && !st_q.diag.rate_found
    |=> var_data_o == 16'h0000)
    else $error("Divisor nonzero before rate found");
  a_uptime_step: assert property (
    $past(!sys_rst_i) && st_q.uptime != $past(st_q.uptime) |-> st_q.uptime == $past(st_q.uptime) + 32'h0000_0001)
    else $error("Uptime did not step by one");
  a_ack_timing: assert property (
    var_req_i |=> var_ack_o)
    else $error("Answer strobe missing one cycle after request");
  a_ack_single: assert property (
    !var_req_i |=> !var_ack_o)
    else $error("Answer strobe without a request");

  c_pulse_valid: cover property (!st_q.pulse[0].valid ##1 st_q.pulse[0].valid);
  c_pulse_lost: cover property (st_q.pulse[1].valid ##1 !st_q.pulse[1].valid);
  c_scaled_read: cover property (var_req_i && var_id_i == ID_PULSE1_SCALED && st_q.pulse[0].valid);
  c_unknown_read: cover property (var_ack_o && var_unknown_o);

endmodule // variable_bank

// >>> test/var_host_model.sv
// Host model that issues variable read requests and collects the answers
`timescale 1ns/1ps
module var_host_model
(
  input wire logic clock_i,
  input wire logic var_ack_i,
  input wire logic [15:0] var_data_i,
  input wire logic var_unknown_i,
  output logic var_req_o,
  output logic [7:0] var_id_o
);
  // ------------------------------------------------------------------
  // Idle request lines from time zero
  // ------------------------------------------------------------------
  initial
  begin
    var_req_o = 1'b0;
    var_id_o = 8'h00;
  end

  // One request cycle, then a bounded wait for the acknowledge pulse
  task automatic read_var(input logic [7:0] id, output logic [15:0] data, output logic unk, output logic ok);
    int n;
    @(posedge clock_i);
    #1;
    var_req_o = 1'b1;
    var_id_o = id;
    @(posedge clock_i);
    #1;
    var_req_o = 1'b0;
    var_id_o = ~id; // No longer qualified, so it carries junk
    n = 0;
    while (var_ack_i !== 1'b1 && n < 4)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    ok = (var_ack_i === 1'b1);
    data = var_data_i;
    unk = var_unknown_i;
  endtask
endmodule // var_host_model

// >>> test/input_and_diagnostic_variables_tb_top.sv
// Self-checking bench for the controller variable bank
`timescale 1ns/1ps
module input_and_diagnostic_variables_tb_top;
  import variable_bank_pkg::*;
  localparam int MS_SIM = 1; // One cycle per millisecond so the high word is reached
  logic clock_i, sys_rst_i, pin_one, pin_two, adc_strobe, adc_ch, open_en, req, ack, unk;
  logic [11:0] adc_code;
  logic [1:0] pot_open;
  cal_t [3:0] cal;
  diag_t diag;
  logic [7:0] req_id;
  logic [15:0] rd_data;
  int miscompares, n_checks, cycles, rel_cycle, sp, tp;
  int raw[4]; // Model of unlimited raw value per channel
  int code[2]; // Model of stored converter code per analog channel
  logic [7:0] base[4] = '{ID_PULSE1_UNLIM, ID_PULSE2_UNLIM, ID_ANALOG1_UNLIM, ID_ANALOG2_UNLIM};

  // ------------------------------------------------------------------
  // Design and host model
  // ------------------------------------------------------------------
  variable_bank #(.MS_CYCLES(MS_SIM)) u_variable_bank (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .pulse_input_one_i(pin_one), .pulse_input_two_i(pin_two), .adc_strobe_i(adc_strobe),
    .adc_channel_i(adc_ch), .adc_code_i(adc_code), .pot_open_i(pot_open), .open_detect_en_i(open_en),
    .channel_cal_i(cal), .diag_i(diag), .var_req_i(req), .var_id_i(req_id), .var_ack_o(ack),
    .var_data_o(rd_data), .var_unknown_o(unk));
  var_host_model u_var_host_model (.clock_i(clock_i), .var_ack_i(ack), .var_data_i(rd_data),
    .var_unknown_i(unk), .var_req_o(req), .var_id_o(req_id));

  // Clock and hang guard
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  // ------------------------------------------------------------------
  // Model of limited and scaled values
  // ------------------------------------------------------------------
  function automatic int lim_of(int ch);
    if (raw[ch] == 65535 || raw[ch] < cal[ch].err_min || raw[ch] > cal[ch].err_max)
      return 65535;
    return raw[ch];
  endfunction
  function automatic int scaled_of(int ch);
    int v;
    if (lim_of(ch) == 65535)
      return 0;
    v = ((lim_of(ch) - int'(cal[ch].neutral)) * int'(cal[ch].gain)) >>> 8;
    return v > 3200 ? 3200 : (v < -3200 ? -3200 : v);
  endfunction

  // Read one variable and compare it, signed, within a tolerance
  task automatic check_var(input logic [7:0] id, input int exp, input int tol);
    logic [15:0] d;
    logic u, ok;
    int diff;
    u_var_host_model.read_var(id, d, u, ok);
    n_checks++;
    diff = int'($signed(d)) - int'($signed(16'(exp)));
    if (ok !== 1'b1 || u !== 1'b0 || (^d) === 1'bx || diff > tol || diff < -tol)
    begin
      miscompares++;
      $display("wrong value at %0t: id %h got %h exp %h", $time, id, d, 16'(exp));
    end
  endtask
  // Read an unmapped identifier: zero data and the unknown flag
  task automatic check_unmapped(input logic [7:0] id);
    logic [15:0] d;
    logic u, ok;
    u_var_host_model.read_var(id, d, u, ok);
    n_checks++;
    if (ok !== 1'b1 || u !== 1'b1 || d !== 16'h0000)
    begin
      miscompares++;
      $display("wrong value at %0t: unmapped id %h answered %h", $time, id, d);
    end
  endtask
  // Three variables of one channel
  task automatic check_channel(input int ch, input int tol_raw, input int tol_sc);
    check_var(base[ch], raw[ch], tol_raw);
    check_var(base[ch] + 8'h01, lim_of(ch), tol_raw);
    check_var(base[ch] + 8'h02, scaled_of(ch), tol_sc);
  endtask
  task automatic pulse_train(ref logic pin, input int high, input int low, input int n);
    repeat (n)
    begin
      pin = 1'b1;
      repeat (high) @(posedge clock_i);
      #1 pin = 1'b0;
      repeat (low) @(posedge clock_i);
      #1;
    end
  endtask
  task automatic do_reset();
    sys_rst_i = 1'b1;
    repeat (4) @(posedge clock_i);
    #1 sys_rst_i = 1'b0;
    rel_cycle = cycles;
    raw = '{65535, 65535, 0, 0};
    code = '{0, 0};
  endtask
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    {pin_one, pin_two, adc_strobe, adc_ch, open_en, adc_code, pot_open, diag} = '0;
    cal[0] = '{16'h0190, 16'h2ee0, 16'h0226, 16'h0800};
    cal[1] = '{16'h0190, 16'h02bc, 16'h0226, 16'h0800};
    cal[2] = '{16'h0100, 16'h0e00, 16'h0800, 16'h0180};
    cal[3] = '{16'h0100, 16'h0e00, 16'h0800, 16'h0300};
    void'($urandom(32'hcc96a1c6));
    do_reset();
    // Reset state: no pulse signal, cleared analog codes, unmapped id
    for (int c = 0; c < 4; c++) check_channel(c, 0, 0);
    check_var(ID_PULSE_PERIOD, 0, 0);
    check_unmapped(8'h07);
    $display("test reset state done");
    // Diagnostics with random values
    repeat (20)
    begin
      sp = ($urandom_range(2) == 0) ? 0 : int'($urandom_range(6400)) - 3200;
      tp = int'($urandom_range(2000)) - 500;
      diag = '{16'($urandom_range(6400) - 3200), 16'(sp), 6'($urandom_range(32)), 16'($urandom),
        16'(tp), 16'($urandom), 1'($urandom), 1'($urandom)};
      check_var(ID_REQUESTED_SPEED, int'(diag.target), 0);
      check_var(ID_APPLIED_SPEED, sp, 0);
      check_var(ID_BRAKING, sp == 0 ? int'(diag.brake) : 255, 0);
      check_var(ID_SUPPLY_MV, int'(diag.supply_mv), 0);
      check_var(ID_TEMPERATURE, tp < 0 ? 0 : tp, 0);
      check_var(ID_RATE_DIVISOR, (diag.auto_rate && !diag.rate_found) ? 0 : int'(diag.divisor), 0);
    end
    $display("test diagnostics done");
    // Analog results, open detection on and off, both channels
    repeat (16)
    begin
      adc_ch = 1'($urandom);
      adc_code = 12'($urandom);
      open_en = 1'($urandom);
      pot_open = 2'($urandom);
      adc_strobe = 1'b1;
      @(posedge clock_i);
      #1 adc_strobe = 1'b0;
      code[adc_ch] = int'(adc_code);
      for (int c = 0; c < 2; c++)
        raw[2 + c] = (open_en && pot_open[c]) ? 65535 : code[c];
      check_channel(2, 0, 0);
      check_channel(3, 0, 0);
    end
    $display("test analog done");
    // Pulse below the window, then both channels measured together
    pulse_train(pin_one, 1000, 1250, 1);
    check_channel(0, 0, 0);
    fork
      pulse_train(pin_one, 3750, 1250, 2);
      pulse_train(pin_two, 5000, 1250, 1);
    join
    raw[0] = 600;
    raw[1] = 800;
    check_channel(0, 1, 9);
    check_channel(1, 1, 9);
    check_var(ID_PULSE_PERIOD, 2, 1);
    $display("test pulses done");
    // Uptime, then a second reset restarts it
    check_var(ID_UPTIME_LOW, (cycles - rel_cycle) / MS_SIM, 2);
    check_var(ID_UPTIME_HIGH, 0, 0);
    // Run past the first carry into the high word
    while (cycles - rel_cycle < 65600) @(posedge clock_i);
    #1;
    check_var(ID_UPTIME_HIGH, 1, 0);
    check_var(ID_UPTIME_LOW, (cycles - rel_cycle) - 65536, 2);
    do_reset();
    check_var(ID_UPTIME_LOW, 0, 1);
    check_channel(0, 0, 0);
    $display("test uptime done");
    wrap_up();
  end
endmodule // input_and_diagnostic_variables_tb_top
